// >>> core/pwm_pkg.sv
// package: register map, field positions, reset values and types of the pwm block
package pwm_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] time_base_control_addr = 8'h00;
  localparam logic [7:0] period_value_addr      = 8'h04;
  localparam logic [7:0] compare_shadow_addr    = 8'h08;
  localparam logic [7:0] compare_a_active_addr  = 8'h0c;
  localparam logic [7:0] phase_value_addr       = 8'h10;
  localparam logic [7:0] rise_delay_addr        = 8'h14;
  localparam logic [7:0] fall_delay_addr        = 8'h18;
  localparam logic [7:0] status_addr            = 8'h1c;

  // ----------------------------------------------------------------
  // control and status field positions
  // ----------------------------------------------------------------
  localparam int run_bit        = 0;
  localparam int load_lsb       = 1;
  localparam int sync_out_lsb   = 4;
  localparam int sync_in_en_bit = 6;
  localparam int sync_src_lsb   = 8;
  localparam int event_en_bit   = 10;
  localparam int act_up_lsb     = 12;
  localparam int act_down_lsb   = 14;
  localparam int dead_en_bit    = 16;
  localparam int force_sync_bit = 17;
  localparam int flag_bit       = 0;
  localparam int dir_bit        = 1;
  localparam int count_lsb      = 16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] period_reset  = 16'h0000;
  localparam logic [15:0] compare_reset = 16'h0000;
  localparam logic [15:0] phase_reset   = 16'h0000;
  localparam logic [15:0] delay_reset   = 16'h0000;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    load_at_zero, load_at_period, load_at_both, load_now
  } load_mode_t;
  typedef enum logic [1:0] {
    sync_out_off, sync_out_pass, sync_out_zero, sync_out_none
  } sync_out_mode_t;
  typedef enum logic [1:0] {
    src_neighbour, src_timer, src_pin, src_none
  } sync_src_t;
  typedef enum logic [1:0] {
    act_none, act_low, act_high, act_toggle
  } action_t;

  typedef struct packed {
    logic           dead_en;
    action_t        act_down;
    action_t        act_up;
    logic           event_en;
    sync_src_t      sync_src;
    logic           sync_in_en;
    sync_out_mode_t sync_out_mode;
    load_mode_t     load_mode;
    logic           run;
  } control_t;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_t;

endpackage : pwm_pkg

// >>> core/pwm_timebase_compare_sync.sv
// pwm channel pair: up-down time base, shadowed compare, actions, dead band, sync
//
// Notes on behaviour
// - sixteen bit counter runs against programmable period
// - up-count match drives high, down-count drives low
// - compare shadow loads into active at chosen point
// - period match raises event when enabled
// - delayed waveform and inverse give complementary pair
// - rising and falling delays programmed separately
// - opposite polarity selectable per count direction
// - counter zero can drive sync output
// - received sync can pass straight to output
// - sync input from neighbour, timer or pin
// - sync loads counter with programmed phase value
// - software force sync loads this module; the global force input hits several modules together
`timescale 1ns/10ps

module pwm_timebase_compare_sync #(
  parameter int width = 16
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 sync_neighbour_i,
  input  wire logic                 sync_timer_i,
  input  wire logic                 sync_pin_i,
  input  wire logic                 global_force_sync_i,
  output logic                      sync_out_o,
  output logic                      pwm_a_o,
  output logic                      pwm_b_o,
  output logic                      period_event_o
);
  import pwm_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  control_t         ctrl;
  logic [width-1:0] period_value;
  logic [width-1:0] compare_shadow;
  logic [width-1:0] compare_a_active;
  logic [width-1:0] phase_value;
  logic [width-1:0] rise_delay;
  logic [width-1:0] fall_delay;
  logic             period_flag;
  logic             soft_force_sync;

  logic [width-1:0] time_base_count;
  logic             count_up;
  logic             wave;
  logic [width-1:0] rise_cnt;
  logic [width-1:0] fall_cnt;
  logic             rise_out;
  logic             fall_out;
  logic [2:0]       pin_sync;
  logic             pin_level;
  logic             pin_event;
  logic             sync_event;
  logic             sync_rx;
  logic             at_zero;
  logic             at_period;
  logic             at_compare;
  logic             load_point;
  logic             bus_req;
  logic             bus_write;
  logic [31:0]      wdata;
  logic [31:0]      next_rdata;
  action_t          act;

  // ----------------------------------------------------------------
  // wishbone classic slave
  // ----------------------------------------------------------------
  // ack one cycle after the request; writes land on the ack edge
  assign bus_req   = wb_cyc_i & wb_stb_i;
  assign bus_write = bus_req & wb_we_i & wb_ack_o;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wdata[i*8 +: 8] = wb_sel_i[i] ? wb_dat_i[i*8 +: 8] : 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      time_base_control_addr: begin
        next_rdata[run_bit]           = ctrl.run;
        next_rdata[load_lsb +: 2]     = ctrl.load_mode;
        next_rdata[sync_out_lsb +: 2] = ctrl.sync_out_mode;
        next_rdata[sync_in_en_bit]    = ctrl.sync_in_en;
        next_rdata[sync_src_lsb +: 2] = ctrl.sync_src;
        next_rdata[event_en_bit]      = ctrl.event_en;
        next_rdata[act_up_lsb +: 2]   = ctrl.act_up;
        next_rdata[act_down_lsb +: 2] = ctrl.act_down;
        next_rdata[dead_en_bit]       = ctrl.dead_en;
      end
      period_value_addr:      next_rdata[width-1:0] = period_value;
      compare_shadow_addr:    next_rdata[width-1:0] = compare_shadow;
      compare_a_active_addr:  next_rdata[width-1:0] = compare_a_active;
      phase_value_addr:       next_rdata[width-1:0] = phase_value;
      rise_delay_addr:        next_rdata[width-1:0] = rise_delay;
      fall_delay_addr:        next_rdata[width-1:0] = fall_delay;
      status_addr: begin
        next_rdata[flag_bit] = period_flag;
        next_rdata[dir_bit]  = count_up;
        next_rdata[count_lsb +: width] = time_base_count;
      end
      default:                next_rdata = 32'h0000_0000;
    endcase
  end

  // unmapped reads give zero, unmapped writes are dropped, both acked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req & ~wb_ack_o & ~wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl         <= '0;
      period_value <= period_reset;
      phase_value  <= phase_reset;
      rise_delay   <= delay_reset;
      fall_delay   <= delay_reset;
    end else if (bus_write) begin
      unique case (wb_adr_i)
        time_base_control_addr: begin
          ctrl.run           <= wdata[run_bit];
          ctrl.load_mode     <= load_mode_t'(wdata[load_lsb +: 2]);
          ctrl.sync_out_mode <= sync_out_mode_t'(wdata[sync_out_lsb +: 2]);
          ctrl.sync_in_en    <= wdata[sync_in_en_bit];
          ctrl.sync_src      <= sync_src_t'(wdata[sync_src_lsb +: 2]);
          ctrl.event_en      <= wdata[event_en_bit];
          ctrl.act_up        <= action_t'(wdata[act_up_lsb +: 2]);
          ctrl.act_down      <= action_t'(wdata[act_down_lsb +: 2]);
          ctrl.dead_en       <= wdata[dead_en_bit];
        end
        period_value_addr:      period_value <= wdata[width-1:0];
        phase_value_addr:       phase_value <= wdata[width-1:0];
        rise_delay_addr:        rise_delay <= wdata[width-1:0];
        fall_delay_addr:        fall_delay <= wdata[width-1:0];
        default: ;
      endcase
    end
  end

  // self-clearing: a write of one gives a single sync pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_force_sync <= 1'b0;
    end else begin
      soft_force_sync <= bus_write & (wb_adr_i == time_base_control_addr)
                         & wdata[force_sync_bit];
    end
  end

  // ----------------------------------------------------------------
  // sync input
  // ----------------------------------------------------------------
  // the pin is asynchronous; a change counts when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_sync  <= 3'h0;
      pin_level <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], sync_pin_i};
      if (pin_sync[1] == pin_sync[2]) begin
        pin_level <= pin_sync[2];
      end
    end
  end

  assign pin_event = (pin_sync[1] == pin_sync[2]) & pin_sync[2] & ~pin_level;

  always_comb begin
    unique case (ctrl.sync_src)
      src_neighbour: sync_rx = sync_neighbour_i;
      src_timer:     sync_rx = sync_timer_i;
      src_pin:       sync_rx = pin_event;
      default:       sync_rx = 1'b0;
    endcase
  end

  // the global force reaches every module at once, bypassing any chain
  assign sync_event = (ctrl.sync_in_en & sync_rx) | soft_force_sync
                      | global_force_sync_i;

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  assign at_zero    = (time_base_count == '0);
  assign at_period  = (time_base_count == period_value);
  assign at_compare = (time_base_count == compare_a_active);

  // counts 0..period..0, so one cycle takes twice the period value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      time_base_count <= '0;
      count_up        <= 1'b1;
    end else if (sync_event) begin
      time_base_count <= phase_value;
    end else if (ctrl.run) begin
      if (count_up) begin
        if (at_period) begin
          count_up        <= 1'b0;
          time_base_count <= time_base_count - 1'b1;
        end else begin
          time_base_count <= time_base_count + 1'b1;
        end
      end else if (at_zero) begin
        count_up        <= 1'b1;
        time_base_count <= time_base_count + 1'b1;
      end else begin
        time_base_count <= time_base_count - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // compare double buffer
  // ----------------------------------------------------------------
  always_comb begin
    unique case (ctrl.load_mode)
      load_at_zero:   load_point = at_zero;
      load_at_period: load_point = at_period;
      load_at_both:   load_point = at_zero | at_period;
      load_now:       load_point = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_shadow <= compare_reset;
    end else if (bus_write & (wb_adr_i == compare_shadow_addr)) begin
      compare_shadow <= wdata[width-1:0];
    end
  end

  // a stopped counter still loads, so the first period uses the new value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_a_active <= compare_reset;
    end else if (load_point) begin
      compare_a_active <= compare_shadow;
    end
  end

  // ----------------------------------------------------------------
  // period event
  // ----------------------------------------------------------------
  // a new match in the clearing cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_flag <= 1'b0;
    end else if (ctrl.run & at_period & ctrl.event_en) begin
      period_flag <= 1'b1;
    end else if (bus_write & (wb_adr_i == status_addr) & wdata[flag_bit]) begin
      period_flag <= 1'b0;
    end
  end

  assign period_event_o = period_flag & ctrl.event_en;

  // ----------------------------------------------------------------
  // action qualifier
  // ----------------------------------------------------------------
  // up_action=high, down_action=low is the usual form; swap for inversion
  assign act = count_up ? ctrl.act_up : ctrl.act_down;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wave <= 1'b0;
    end else if (ctrl.run & at_compare) begin
      unique case (act)
        act_low:    wave <= 1'b0;
        act_high:   wave <= 1'b1;
        act_toggle: wave <= ~wave;
        act_none:   wave <= wave;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // dead band
  // ----------------------------------------------------------------
  // rise_out follows wave up only after rise_delay cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rise_cnt <= '0;
      rise_out <= 1'b0;
    end else if (!wave) begin
      rise_cnt <= '0;
      rise_out <= 1'b0;
    end else if (rise_cnt >= rise_delay) begin
      rise_out <= 1'b1;
    end else begin
      rise_cnt <= rise_cnt + 1'b1;
    end
  end

  // fall_out follows wave down only after fall_delay cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fall_cnt <= '0;
      fall_out <= 1'b0;
    end else if (wave) begin
      fall_cnt <= '0;
      fall_out <= 1'b1;
    end else if (fall_cnt >= fall_delay) begin
      fall_out <= 1'b0;
    end else begin
      fall_cnt <= fall_cnt + 1'b1;
    end
  end

  // rise_out high implies fall_out high, so a and b never overlap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_a_o <= 1'b0;
      pwm_b_o <= 1'b0;
    end else if (ctrl.dead_en) begin
      pwm_a_o <= rise_out;
      pwm_b_o <= ~fall_out;
    end else begin
      pwm_a_o <= wave;
      pwm_b_o <= ~wave;
    end
  end

  // ----------------------------------------------------------------
  // sync output
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_out_o <= 1'b0;
    end else begin
      unique case (ctrl.sync_out_mode)
        sync_out_pass: sync_out_o <= sync_event;
        sync_out_zero: sync_out_o <= ctrl.run & at_zero;
        default:       sync_out_o <= 1'b0;
      endcase
    end
  end

endmodule : pwm_timebase_compare_sync

// >>> test/pwm_far_side.sv
// far-side model: neighbour, timer and pin sync sources, gate driver watch
`timescale 1ns/10ps
module pwm_far_side (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [2:0] sel_i,
  input  wire logic       pwm_a_i,
  input  wire logic       pwm_b_i,
  output logic            sync_neighbour_o,
  output logic            sync_timer_o,
  output logic            sync_pin_o,
  output logic            global_force_sync_o,
  output logic            shoot_o
);
  logic [2:0] pin_hold;
  initial begin
    {sync_neighbour_o, sync_timer_o, sync_pin_o} = 3'h0;
    {global_force_sync_o, shoot_o} = 2'h0;
    pin_hold = 3'h0;
  end
  // one-cycle pulses on the block's own clock
  always @(posedge clk_i) begin
    sync_neighbour_o    <= go_i && sel_i == 3'h0;
    sync_timer_o        <= go_i && sel_i == 3'h1;
    global_force_sync_o <= go_i && sel_i == 3'h4;
  end
  // the pin is a held level, so its rise must count only once
  always @(posedge clk_i) begin
    if (go_i && sel_i == 3'h2) begin
      pin_hold <= 3'h4;
    end else if (pin_hold != 3'h0) begin
      pin_hold <= pin_hold - 3'h1;
    end
    sync_pin_o <= pin_hold != 3'h0;
  end
  // both switches on together would short the bridge
  always @(posedge clk_i) begin
    shoot_o <= shoot_o | (pwm_a_i & pwm_b_i);
  end
endmodule : pwm_far_side

// >>> test/pwm_timebase_compare_sync_properties.sv
// checker: bus handshake, output pair and event flag relations
`timescale 1ns/10ps
module pwm_port_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        pwm_a_o,
  input wire logic        pwm_b_o,
  input wire logic        period_event_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_seen;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_follows_req: assert property (req_seen |=> ack_pulse)
    else $error("ack not one cycle after request");
  a_ack_needs_req: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  a_no_idle_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack while idle");
  a_rdata_holds: assert property (
    $changed(wb_dat_o) |-> (wb_ack_o && !wb_we_i) || $past(rst_i))
    else $error("read data moved outside a read");
  a_unmapped_read: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i > 8'h1c |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_pair_apart: assert property (!(pwm_a_o && pwm_b_o))
    else $error("both outputs active");
  a_event_holds: assert property (
    period_event_o && !(wb_ack_o && wb_we_i) |=> period_event_o)
    else $error("event dropped without write");
  a_event_falls: assert property (
    $fell(period_event_o) |-> $past(wb_ack_o && wb_we_i) || $past(rst_i))
    else $error("event fell without write");
endmodule : pwm_port_checker

bind pwm_timebase_compare_sync pwm_port_checker pwm_port_checker_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pwm_a_o(pwm_a_o), .pwm_b_o(pwm_b_o),
  .period_event_o(period_event_o));

// >>> test/pwm_timebase_compare_sync_tb_top.sv
// testbench: bus tasks and scenarios for the pwm channel pair
`timescale 1ns/10ps
module pwm_timebase_compare_sync_tb_top;
  import pwm_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  wb_req_t     req   = '0;
  logic        go    = 1'b0;
  logic [2:0]  sel   = 3'h0;
  logic [31:0] wb_dat_o, q;
  logic        wb_ack_o, sync_out_o, pwm_a_o, pwm_b_o, period_event_o;
  logic        nb_s, tm_s, pin_s, gl_s, shoot;
  int          err_total = 0;
  int          comparisons = 0;
  int          hi, per, k;
  always #2.5 clk_i = ~clk_i;
  pwm_timebase_compare_sync pwm_timebase_compare_sync_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr),
    .wb_dat_i(req.dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sync_neighbour_i(nb_s), .sync_timer_i(tm_s), .sync_pin_i(pin_s),
    .global_force_sync_i(gl_s), .sync_out_o(sync_out_o),
    .pwm_a_o(pwm_a_o), .pwm_b_o(pwm_b_o), .period_event_o(period_event_o));
  pwm_far_side pwm_far_side_i (
    .clk_i(clk_i), .go_i(go), .sel_i(sel), .pwm_a_i(pwm_a_o),
    .pwm_b_i(pwm_b_o), .sync_neighbour_o(nb_s), .sync_timer_o(tm_s),
    .sync_pin_o(pin_s), .global_force_sync_o(gl_s), .shoot_o(shoot));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task check(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task wb_io(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    req <= '{cyc:1'b1, stb:1'b1, we:we, sel:4'hf, adr:a, dat:d};
    @(posedge clk_i);
    n = 1;
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    q = wb_dat_o;
    req <= '0;
    if (n >= 50) err_total++;
  endtask : wb_io
  function automatic logic pick(input int s);
    return (s != 0) ? pwm_b_o : pwm_a_o;
  endfunction : pick
  // count cycles high, then to the next rise; the first wave after a
  // change may be partial, so callers measure twice
  task meas(input int s);
    hi = 0;
    per = 0;
    while (pick(s) !== 1'b0 && per < 300) @(posedge clk_i) per++;
    while (pick(s) !== 1'b1 && per < 600) @(posedge clk_i) per++;
    while (pick(s) === 1'b1 && hi < 300) @(posedge clk_i) hi++;
    per = hi;
    while (pick(s) === 1'b0 && per < 300) @(posedge clk_i) per++;
  endtask : meas
  task fire(input logic [2:0] s);
    @(posedge clk_i);
    sel <= s;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask : fire
  task wait_high(input int lim);
    int n;
    n = 0;
    while (sync_out_o !== 1'b1 && n < lim) @(posedge clk_i) n++;
  endtask : wait_high
  task complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (k = 0; k <= 8; k++) begin
      wb_io(1'b0, 8'(k * 4), 32'h0);
      check("reset value", q, (k == 7) ? 32'h2 : 32'h0);
    end
    wb_io(1'b1, period_value_addr, 32'h8);
    wb_io(1'b1, compare_shadow_addr, 32'h2);
    wb_io(1'b0, compare_a_active_addr, 32'h0);
    check("active compare", q, 32'h2);
    wb_io(1'b1, time_base_control_addr, 32'h6401);
    repeat (2) meas(0);
    check("high time", hi, 32'hc);
    check("wave period", per, 32'h10);
    wb_io(1'b1, compare_shadow_addr, 32'h4);
    repeat (2) meas(0);
    check("reloaded high", hi, 32'h8);
    wait_high(0);
    k = 0;
    while (period_event_o !== 1'b1 && k < 40) @(posedge clk_i) k++;
    wb_io(1'b0, status_addr, 32'h0);
    check("event flag", q[0], 32'h1);
    repeat (40) @(posedge clk_i);
    check("event held", period_event_o, 32'h1);
    wb_io(1'b1, time_base_control_addr, 32'h0);
    wb_io(1'b1, status_addr, 32'h1);
    wb_io(1'b0, status_addr, 32'h0);
    check("flag cleared", q[0], 32'h0);
    wb_io(1'b1, compare_shadow_addr, 32'h2);
    wb_io(1'b1, time_base_control_addr, 32'h9401);
    repeat (2) meas(0);
    check("inverted high", hi, 32'h4);
    wb_io(1'b1, rise_delay_addr, 32'h2);
    wb_io(1'b1, fall_delay_addr, 32'h1);
    wb_io(1'b1, time_base_control_addr, 32'h16401);
    repeat (2) meas(0);
    check("delayed a", hi, 32'ha);
    repeat (2) meas(1);
    check("delayed b", hi, 32'h3);
    // neighbour, timer, pin, soft force, shared force
    for (k = 0; k < 5; k++) begin
      wb_io(1'b1, time_base_control_addr, 32'h0);
      wb_io(1'b1, phase_value_addr, 32'(k + 3));
      if (k == 3) begin
        wb_io(1'b1, time_base_control_addr, 32'h20000);
      end else begin
        wb_io(1'b1, time_base_control_addr, 32'h40 | 32'((k & 3) << 8));
        fire(3'(k));
      end
      repeat (6) @(posedge clk_i);
      wb_io(1'b0, status_addr, 32'h0);
      check("phase load", q[31:16], 32'(k + 3));
    end
    wb_io(1'b1, time_base_control_addr, 32'h6);
    wb_io(1'b1, compare_shadow_addr, 32'h5);
    wb_io(1'b0, compare_a_active_addr, 32'h0);
    check("immediate load", q, 32'h5);
    wb_io(1'b1, time_base_control_addr, 32'h50);
    fire(3'h0);
    wait_high(6);
    check("pass sync", sync_out_o, 32'h1);
    wb_io(1'b1, time_base_control_addr, 32'h21);
    wait_high(40);
    check("zero sync", sync_out_o, 32'h1);
    check("no overlap", shoot, 32'h0);
    complete_run();
  end
endmodule : pwm_timebase_compare_sync_tb_top
